// file: adcrs_defines.svh
`ifndef ADCRS_DEFINES_SVH
`define ADCRS_DEFINES_SVH

`define ADCRS_NCH 8
`define ADCRS_CHW 3
`define ADCRS_DW 10

`define ADCRS_OFS_CH_ENABLE 12'h000
`define ADCRS_OFS_CH_DISABLE 12'h004
`define ADCRS_OFS_CH_STATE 12'h008
`define ADCRS_OFS_STATUS 12'h00c
`define ADCRS_OFS_LAST 12'h010
`define ADCRS_OFS_CHRES_BASE 12'h020
`define ADCRS_OFS_CHRES_LAST 12'h03c

`define ADCRS_ST_DONE_LSB 0
`define ADCRS_ST_OVR_LSB 8
`define ADCRS_ST_READY_BIT 16
`define ADCRS_ST_GOVR_BIT 17
`define ADCRS_LAST_CH_LSB 12

`define ADCRS_RST_ENABLE 8'h00

`endif

// file: adcrs_pkg.sv
`default_nettype none
package adcrs_pkg;
	typedef logic [9:0] adcrs_data_t;
	typedef logic [2:0] adcrs_chan_t;
	typedef logic [7:0] adcrs_mask_t;
	typedef enum logic [2:0] {
		ADCRS_ACC_NONE,
		ADCRS_ACC_STATUS,
		ADCRS_ACC_LAST,
		ADCRS_ACC_CHRES,
		ADCRS_ACC_OTHER
	} adcrs_acc_e;
endpackage
`default_nettype wire

// file: adcrs_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
interface adcrs_mem_if;
	logic wr_en;
	adcrs_pkg::adcrs_chan_t wr_addr;
	adcrs_pkg::adcrs_data_t wr_data;
	adcrs_pkg::adcrs_chan_t rd_addr;
	adcrs_pkg::adcrs_data_t rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// file: adcrs_result_mem.sv
`timescale 1ns/10ps
`default_nettype none
`include "adcrs_defines.svh"
module adcrs_result_mem (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Access port.
	adcrs_mem_if.mem m
);
	adcrs_pkg::adcrs_data_t store [`ADCRS_NCH];

	////////////////////////////////////////////////////////////////
	// One result word per channel.
	genvar gi;
	generate
		for (gi = 0; gi < `ADCRS_NCH; gi++) begin : g_entry
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					store[gi] <= 10'h000;
				end else if (m.wr_en && m.wr_addr == 3'(gi)) begin
					store[gi] <= m.wr_data;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Registered read port.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m.rd_data <= 10'h000;
		end else begin
			m.rd_data <= store[m.rd_addr];
		end
	end
endmodule // adcrs_result_mem
`default_nettype wire

// file: adcrs_top.sv
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "adcrs_defines.svh"
module adcrs_top (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Converter completion.
	input wire logic conv_done,
	input wire logic [2:0] conv_channel,
	input wire logic [9:0] conv_data,
	// Channel enables towards the sequencer.
	output logic [7:0] chan_enabled
);
	adcrs_mem_if mif ();
	adcrs_result_mem u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.m(mif.mem)
	);

	adcrs_pkg::adcrs_mask_t chan_en;
	adcrs_pkg::adcrs_mask_t done_flag;
	adcrs_pkg::adcrs_mask_t channel_overrun_flag;
	logic conversion_ready_flag;
	logic global_overrun_flag;
	adcrs_pkg::adcrs_data_t last_result_reg;
	adcrs_pkg::adcrs_chan_t last_chan;

	////////////////////////////////////////////////////////////////
	// Address decode.
	adcrs_pkg::adcrs_acc_e acc;
	logic mapped;
	logic access;
	logic rd_access;
	logic wr_access;
	logic rd_status;
	logic rd_last;
	adcrs_pkg::adcrs_mask_t rd_chres;
	adcrs_pkg::adcrs_chan_t addr_chan;

	assign addr_chan = paddr[4:2];

	always_comb begin
		acc = adcrs_pkg::ADCRS_ACC_NONE;
		if (paddr[1:0] == 2'h0) begin
			if (paddr == `ADCRS_OFS_STATUS) begin
				acc = adcrs_pkg::ADCRS_ACC_STATUS;
			end else if (paddr == `ADCRS_OFS_LAST) begin
				acc = adcrs_pkg::ADCRS_ACC_LAST;
			end else if (paddr >= `ADCRS_OFS_CHRES_BASE && paddr <= `ADCRS_OFS_CHRES_LAST) begin
				acc = adcrs_pkg::ADCRS_ACC_CHRES;
			end else if (paddr == `ADCRS_OFS_CH_ENABLE || paddr == `ADCRS_OFS_CH_DISABLE ||
					paddr == `ADCRS_OFS_CH_STATE) begin
				acc = adcrs_pkg::ADCRS_ACC_OTHER;
			end
		end
	end

	assign mapped = (acc != adcrs_pkg::ADCRS_ACC_NONE);
	assign access = psel && penable;
	assign rd_access = access && !pwrite && mapped;
	assign wr_access = access && pwrite && mapped;
	assign rd_status = rd_access && acc == adcrs_pkg::ADCRS_ACC_STATUS;
	assign rd_last = rd_access && acc == adcrs_pkg::ADCRS_ACC_LAST;

	// Zero-wait slave; unmapped addresses answer with an error.
	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	////////////////////////////////////////////////////////////////
	// Channel enable register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_en <= `ADCRS_RST_ENABLE;
		end else if (wr_access && paddr == `ADCRS_OFS_CH_ENABLE) begin
			chan_en <= chan_en | pwdata[7:0];
		end else if (wr_access && paddr == `ADCRS_OFS_CH_DISABLE) begin
			chan_en <= chan_en & ~pwdata[7:0];
		end
	end

	assign chan_enabled = chan_en;

	////////////////////////////////////////////////////////////////
	// Completion qualification.
	// The enable sampled is the one in force before any coincident
	// disable write, so disabling another channel cannot mask it.
	logic store_evt;
	adcrs_pkg::adcrs_mask_t store_ch;

	assign store_evt = conv_done && chan_en[conv_channel];

	assign mif.wr_en = store_evt;
	assign mif.wr_addr = conv_channel;
	assign mif.wr_data = conv_data;
	assign mif.rd_addr = addr_chan;

	////////////////////////////////////////////////////////////////
	// Per-channel done and overrun flags.
	genvar gi;
	generate
		for (gi = 0; gi < `ADCRS_NCH; gi++) begin : g_chan
			assign store_ch[gi] = store_evt && conv_channel == 3'(gi);
			assign rd_chres[gi] = rd_access && acc == adcrs_pkg::ADCRS_ACC_CHRES && addr_chan == 3'(gi);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					done_flag[gi] <= 1'b0;
				end else if (store_ch[gi]) begin
					done_flag[gi] <= 1'b1;
				end else if (rd_chres[gi] || rd_last) begin
					done_flag[gi] <= 1'b0;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					channel_overrun_flag[gi] <= 1'b0;
				end else if (store_ch[gi] && done_flag[gi] && conversion_ready_flag) begin
					channel_overrun_flag[gi] <= 1'b1;
				end else if (rd_status) begin
					channel_overrun_flag[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Shared data-ready flag.
	// last-result read clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conversion_ready_flag <= 1'b0;
		end else if (store_evt) begin
			conversion_ready_flag <= 1'b1;
		end else if (rd_last) begin
			conversion_ready_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Global overrun flag.
	// set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_overrun_flag <= 1'b0;
		end else if (store_evt && conversion_ready_flag) begin
			global_overrun_flag <= 1'b1;
		end else if (rd_status) begin
			global_overrun_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Last-result register.
	// shared copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_result_reg <= 10'h000;
			last_chan <= 3'h0;
		end else if (store_evt) begin
			last_result_reg <= conv_data;
			last_chan <= conv_channel;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read data mux; every source is a flip-flop.
	always_comb begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite) begin
			case (acc)
				adcrs_pkg::ADCRS_ACC_STATUS: begin
					prdata[`ADCRS_ST_DONE_LSB +: 8] = done_flag;
					prdata[`ADCRS_ST_OVR_LSB +: 8] = channel_overrun_flag;
					prdata[`ADCRS_ST_READY_BIT] = conversion_ready_flag;
					prdata[`ADCRS_ST_GOVR_BIT] = global_overrun_flag;
				end
				adcrs_pkg::ADCRS_ACC_LAST: begin
					prdata[9:0] = last_result_reg;
					prdata[`ADCRS_LAST_CH_LSB +: 3] = last_chan;
				end
				adcrs_pkg::ADCRS_ACC_CHRES: begin
					prdata[9:0] = mif.rd_data;
				end
				adcrs_pkg::ADCRS_ACC_OTHER: begin
					if (paddr == `ADCRS_OFS_CH_STATE) begin
						prdata[7:0] = chan_en;
					end
				end
				default: begin
					prdata = 32'h0000_0000;
				end
			endcase
		end
	end
endmodule // adcrs_top
`default_nettype wire

// file: adcrs_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module adcrs_checker (
	// Watched ports.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic conv_done,
	input wire logic [2:0] conv_channel,
	input wire logic [9:0] conv_data,
	input wire logic [7:0] chan_enabled
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic ev = conv_done && chan_enabled[conv_channel];
	wire logic [2:0] idx = paddr[4:2];
	sequence rd(logic [11:0] a);
		psel && !penable && !pwrite && paddr == a ##1 psel && penable;
	endsequence
	sequence rd_ch;
		psel && !penable && !pwrite && paddr[11:5] == 7'h01 && paddr[1:0] == 2'h0 ##1 psel && penable;
	endsequence
	sequence quiet_st;
		rd(12'h00c) ##0 !conv_done ##1 !conv_done ##0 rd(12'h00c);
	endsequence
	AST_STORE_FLAGS: assert property (ev ##1 rd(12'h00c) |-> prdata[16] && prdata[$past(conv_channel, 2)])
		else $error("store flags");
	AST_STORE_DATA: assert property (ev ##1 !conv_done ##0 rd(12'h010) |->
		prdata[14:0] == {$past(conv_channel, 2), 2'h0, $past(conv_data, 2)})
		else $error("store data");
	AST_GOVR_SET: assert property (rd(12'h00c) ##0 (prdata[16] && ev) ##1 rd(12'h00c) |-> prdata[17])
		else $error("govr set");
	AST_GOVR_CLR: assert property (quiet_st |-> !prdata[17])
		else $error("govr clear");
	AST_OVR_CLR: assert property (quiet_st |-> prdata[15:8] == 8'h00)
		else $error("ovr clear");
	AST_LAST_CLR: assert property (rd(12'h010) ##0 !conv_done ##1 !conv_done ##0 rd(12'h00c) |->
		prdata[7:0] == 8'h00 && !prdata[16])
		else $error("last clear");
	AST_CH_CLR: assert property (rd_ch ##0 !conv_done ##1 !conv_done ##0 rd(12'h00c) |-> !prdata[$past(idx, 2)])
		else $error("done clear");
	AST_READY_KEPT: assert property (rd(12'h00c) ##0 prdata[16] ##1 rd_ch ##1 rd(12'h00c) |-> prdata[16])
		else $error("ready kept");
endmodule // adcrs_checker
bind adcrs_top adcrs_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .conv_done,
	.conv_channel, .conv_data, .chan_enabled);
`default_nettype wire

// file: testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_done, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] conv_channel;
	logic [9:0] conv_data;
	logic [7:0] chan_enabled;
	int n_errors = 0, n_tests = 0, cyc = 0;
	adcrs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.conv_done, .conv_channel, .conv_data, .chan_enabled);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic complete_run;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 1000) begin
			n_errors++;
			complete_run;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// A conversion pulse, if any, rides on the access cycle.
	task automatic xfer(logic w, logic [11:0] a, logic [31:0] d, logic cv, logic [2:0] ch, logic [9:0] cd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		conv_done <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		conv_done <= cv;
		conv_channel <= ch;
		conv_data <= cd;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0, 1'b0, 3'h0, 10'h0);
		chk(rd, exp);
	endtask
	task automatic pulse(input logic cv, input logic [2:0] ch, input logic [9:0] cd);
		psel <= 1'b0;
		penable <= 1'b0;
		conv_done <= cv;
		conv_channel <= ch;
		conv_data <= cd;
		@(posedge pclk);
	endtask
	task automatic s_basic;
		rc(12'h00c, 32'h0);
		xfer(1'b1, 12'h000, 32'hff, 1'b0, 3'h0, 10'h0);
		pulse(1'b1, 3'h2, 10'h155);
		rc(12'h00c, 32'h10004);
		rc(12'h028, 32'h155);
		rc(12'h00c, 32'h10000);
		rc(12'h010, 32'h2155);
		rc(12'h00c, 32'h0);
		xfer(1'b0, 12'h014, 32'h0, 1'b0, 3'h0, 10'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
	endtask
	task automatic s_overrun;
		pulse(1'b1, 3'h3, 10'h0aa);
		pulse(1'b1, 3'h3, 10'h0ab);
		xfer(1'b0, 12'h00c, 32'h0, 1'b1, 3'h5, 10'h3ff);
		chk(rd, 32'h30808);
		rc(12'h00c, 32'h30028);
		xfer(1'b1, 12'h004, 32'h40, 1'b1, 3'h5, 10'h001);
		rc(12'h00c, 32'h32028);
		rc(12'h00c, 32'h10028);
		rc(12'h008, 32'hbf);
		chk({24'h0, chan_enabled}, 32'hbf);
	endtask
	task automatic s_disable;
		xfer(1'b0, 12'h010, 32'h0, 1'b1, 3'h6, 10'h111);
		chk(rd, 32'h5001);
		rc(12'h00c, 32'h0);
		rc(12'h010, 32'h5001);
		xfer(1'b1, 12'h004, 32'h80, 1'b1, 3'h1, 10'h2aa);
		rc(12'h00c, 32'h10002);
		xfer(1'b0, 12'h020, 32'h0, 1'b1, 3'h1, 10'h2ab);
		chk(rd, 32'h0);
		rc(12'h00c, 32'h30202);
		rc(12'h024, 32'h2ab);
		pulse(1'b1, 3'h0, 10'h123);
		rc(12'h010, 32'h123);
		pulse(1'b1, 3'h0, 10'h124);
		pulse(1'b1, 3'h0, 10'h125);
		rc(12'h020, 32'h125);
		xfer(1'b0, 12'h00c, 32'h0, 1'b1, 3'h0, 10'h126);
		chk(rd, 32'h30100);
		rc(12'h00c, 32'h30001);
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		pulse(1'b0, 3'h0, 10'h0);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		s_basic;
		s_overrun;
		s_disable;
		pulse(1'b0, 3'h0, 10'h0);
		complete_run;
	end
endmodule // testbench
`default_nettype wire
